// [bench/ptc_term_model.sv]
`timescale 1ns/10ps
// ----
// Terminal sink
// ----
module ptc_term_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       tx_vld,
  input  wire logic [7:0] tx_chr,
  output logic            tx_rdy
);
  logic [7:0] got[$];
  logic       ph_r;
  // Slow terminal takes every other cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ph_r <= 1'b0;
    else
      ph_r <= ~ph_r;
  end
  assign tx_rdy = ~slow | ph_r;
  always @(posedge clk)
  begin
    if (!rst && tx_vld && tx_rdy)
      got.push_back(tx_chr);
  end
endmodule : ptc_term_model

// [bench/tb_ptc_core.sv]
`timescale 1ns/10ps
module tb_ptc_core;
  logic clk = 1'b0, rst = 1'b1, online = 1'b1, slow = 1'b0;
  logic set_we = 1'b0, set_remote = 1'b0, brk = 1'b0, at_rate_we = 1'b0;
  logic term_vld = 1'b0, echo_vld = 1'b0, rx_vld = 1'b0;
  logic [7:0] modem_option_register = 8'h00, set_val = 8'h00;
  logic [7:0] term_chr = 8'h00, echo_chr = 8'h00, rx_chr = 8'h00;
  logic [4:0] set_num = 5'h00, at_rate_code = 5'h00;
  logic rx_rdy, tx_vld, tx_rdy, net_vld, net_lf_edit, pkt_intr;
  logic pkt_reset, pkt_brk_ind, to_command, rc_std_en, rc_prompt_en;
  logic set_refused, editing;
  logic [7:0] tx_chr, net_chr, term_type;
  logic [4:0] speed_code;
  logic [7:0] e[$];
  logic [7:0] netq[$];
  logic [4:0] sc[10] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05,
                         5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10};
  int n_mismatch = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  ptc_core i_dut (.clk, .rst, .online, .modem_option_register, .set_we,
    .set_remote, .set_num, .set_val, .at_rate_we, .at_rate_code, .brk,
    .term_vld, .term_chr, .echo_vld, .echo_chr, .rx_vld, .rx_chr, .rx_rdy,
    .tx_vld, .tx_chr, .tx_rdy, .net_vld, .net_chr, .net_lf_edit, .pkt_intr,
    .pkt_reset, .pkt_brk_ind, .to_command, .rc_std_en, .rc_prompt_en,
    .set_refused, .speed_code, .editing, .term_type);
  ptc_term_model m (.clk, .rst, .slow, .tx_vld, .tx_chr, .tx_rdy);

  always @(posedge clk)
  begin
    if (net_vld === 1'b1)
      netq.push_back(net_chr);
  end

  // ----
  // Shared tasks
  // ----
  task automatic chk(input string nm, input logic [7:0] x, s);
    n_checks++;
    if (x !== s)
    begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, x, s);
    end
  endtask : chk

  task automatic cq(input string nm, input logic [7:0] g[$]);
    chk(nm, 8'(e.size()), 8'(g.size()));
    foreach (e[i])
      if (i < g.size())
        chk(nm, e[i], g[i]);
    e.delete();
  endtask : cq

  task automatic cmpq(input string nm);
    // Output has no done flag, so drain for a fixed span
    repeat (60) @(posedge clk);
    cq(nm, m.got);
    m.got.delete();
  endtask : cmpq

  task automatic do_rst;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_rst

  task automatic sp(input logic [4:0] n, input logic [7:0] v, input logic r);
    logic ref_exp;
    ref_exp = !r && (n == 5'h08 || n == 5'h0B);
    set_we <= 1'b1;
    set_num <= n;
    set_val <= v;
    set_remote <= r;
    @(posedge clk);
    set_we <= 1'b0;
    #1;
    chk("refused", 8'(ref_exp), 8'(set_refused));
    @(posedge clk);
  endtask : sp

  task automatic rx(input logic [7:0] c);
    int k;
    rx_vld <= 1'b1;
    rx_chr <= c;
    k = 0;
    // Offer judged mid-cycle, never at the edge that launches it
    @(negedge clk);
    while (k < 300 && rx_rdy !== 1'b1)
    begin
      @(negedge clk);
      k++;
    end
    chk("rx_take", 8'h01, 8'(k < 300));
    @(posedge clk);
    rx_vld <= 1'b0;
    @(posedge clk);
  endtask : rx

  task automatic term(input logic [7:0] c);
    term_vld <= 1'b1;
    term_chr <= c;
    @(posedge clk);
    term_vld <= 1'b0;
    @(posedge clk);
  endtask : term

  task automatic bk(input logic [3:0] x);
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    #1;
    chk("brk", 8'(x), 8'({pkt_intr, pkt_reset, pkt_brk_ind, to_command}));
    @(posedge clk);
  endtask : bk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // ----
  // Scenarios
  // ----
  task automatic t_set;
    logic [2:0] rcv[4] = '{3'h0, 3'h1, 3'h4, 3'h5};
    logic [2:0] v;
    chk("rc_std", 8'h01, 8'(rc_std_en));
    chk("ttype", 8'h02, term_type);
    chk("edit", 8'h00, 8'(editing));
    bk(4'hA);
    foreach (rcv[i])
    begin
      v = rcv[i];
      sp(5'h06, 8'(v), 1'b0);
      // Result enables trail the setting by one more cycle
      @(negedge clk);
      chk("rc_std", 8'(v == 3'h1 || v == 3'h5), 8'(rc_std_en));
      chk("rc_pr", 8'(v == 3'h4 || v == 3'h5), 8'(rc_prompt_en));
      @(posedge clk);
    end
    sp(5'h0F, 8'h01, 1'b0);
    chk("edit", 8'h01, 8'(editing));
    foreach (sc[i])
    begin
      at_rate_we <= 1'b1;
      at_rate_code <= sc[i];
      @(posedge clk);
      at_rate_we <= 1'b0;
      #1;
      chk("speed", 8'(sc[i]), 8'(speed_code));
      @(posedge clk);
    end
    sp(5'h0B, 8'h03, 1'b0);
    chk("speed", 8'h10, 8'(speed_code));
  endtask : t_set

  task automatic t_brk;
    do_rst();
    sp(5'h07, 8'h1F, 1'b0);
    bk(4'hF);
    rx(8'h41);
    cmpq("disc");
    sp(5'h08, 8'h00, 1'b0);
    rx(8'h42);
    cmpq("disc");
    sp(5'h08, 8'h00, 1'b1);
    rx(8'h43);
    e.push_back(8'h43);
    cmpq("undisc");
    modem_option_register <= 8'h04;
    @(posedge clk);
    bk(4'hE);
    online <= 1'b0;
    @(posedge clk);
    bk(4'h0);
    online <= 1'b1;
  endtask : t_brk

  task automatic t_pad;
    do_rst();
    slow <= 1'b1;
    sp(5'h09, 8'h02, 1'b0);
    rx(8'h0D);
    e = '{8'h0D, 8'h00, 8'h00};
    cmpq("crpad");
    sp(5'h0D, 8'h01, 1'b0);
    sp(5'h0E, 8'h01, 1'b0);
    rx(8'h0D);
    e = '{8'h0D, 8'h00, 8'h00, 8'h0A, 8'h00};
    cmpq("lfins");
    online <= 1'b0;
    rx(8'h0D);
    rx(8'h0A);
    e = '{8'h0D, 8'h00, 8'h00, 8'h0A};
    cmpq("offline");
    online <= 1'b1;
    slow <= 1'b0;
  endtask : t_pad

  task automatic t_fold;
    do_rst();
    sp(5'h0A, 8'h02, 1'b0);
    rx(8'h41);
    rx(8'h42);
    rx(8'h43);
    rx(8'h08);
    rx(8'h44);
    rx(8'h45);
    // Tab from column 2 lands on 8, so the second graphic folds
    sp(5'h0A, 8'h09, 1'b0);
    rx(8'h09);
    rx(8'h46);
    rx(8'h47);
    e = '{8'h41, 8'h42, 8'h0D, 8'h0A, 8'h43, 8'h08, 8'h44, 8'h45, 8'h09,
          8'h46, 8'h0D, 8'h0A, 8'h47};
    cmpq("fold");
  endtask : t_fold

  task automatic t_flow;
    do_rst();
    sp(5'h0C, 8'h01, 1'b0);
    sp(5'h0D, 8'h02, 1'b0);
    netq.delete();
    term(8'h13);
    fork
      rx(8'h41);
    join_none
    cmpq("xoff");
    term(8'h11);
    wait fork;
    e.push_back(8'h41);
    cmpq("xon");
    term(8'h0D);
    repeat (4) @(posedge clk);
    e = '{8'h0D, 8'h0A};
    cq("net", netq);
  endtask : t_flow

  task automatic t_echo;
    do_rst();
    sp(5'h0F, 8'h01, 1'b0);
    sp(5'h0D, 8'h07, 1'b0);
    netq.delete();
    // Core idle and output free: the echo is taken at the next edge
    echo_vld <= 1'b1;
    echo_chr <= 8'h0D;
    @(posedge clk);
    echo_vld <= 1'b0;
    e = '{8'h0D, 8'h0A};
    cmpq("echo");
    term(8'h0D);
    @(negedge clk);
    chk("lf_chr", 8'h0A, net_chr);
    chk("lf_edit", 8'h01, 8'(net_lf_edit));
    repeat (3) @(posedge clk);
    e = '{8'h0D, 8'h0A};
    cq("net_ed", netq);
  endtask : t_echo

  initial
  begin
    do_rst();
    t_set();
    t_brk();
    t_pad();
    t_fold();
    t_flow();
    t_echo();
    end_of_test();
  end

  initial
  begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_ptc_core

// [logic/ptc_core.sv]
`timescale 1ns/10ps
`include "ptc_defs.svh"
module ptc_core (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       online,
  input  wire logic [7:0] modem_option_register,
  input  wire logic       set_we,
  input  wire logic       set_remote,
  input  wire logic [4:0] set_num,
  input  wire logic [7:0] set_val,
  input  wire logic       at_rate_we,
  input  wire logic [4:0] at_rate_code,
  input  wire logic       brk,
  input  wire logic       term_vld,
  input  wire logic [7:0] term_chr,
  input  wire logic       echo_vld,
  input  wire logic [7:0] echo_chr,
  input  wire logic       rx_vld,
  input  wire logic [7:0] rx_chr,
  output logic            rx_rdy,
  output logic            tx_vld,
  output logic [7:0]      tx_chr,
  input  wire logic       tx_rdy,
  output logic            net_vld,
  output logic [7:0]      net_chr,
  output logic            net_lf_edit,
  output logic            pkt_intr,
  output logic            pkt_reset,
  output logic            pkt_brk_ind,
  output logic            to_command,
  output logic            rc_std_en,
  output logic            rc_prompt_en,
  output logic            set_refused,
  output logic [4:0]      speed_code,
  output logic            editing,
  output logic [7:0]      term_type
);
  // ------------------------------------------------------------
  // Settings
  // ------------------------------------------------------------
  logic [2:0] rc_sel_r;
  logic [4:0] brk_act_r;
  logic       discard_r;
  logic [7:0] cr_pad_r;
  logic [7:0] line_len_r;
  logic       flow_r;
  logic [2:0] lf_ins_r;
  logic [7:0] lf_pad_r;
  logic       xoff_r;
  ptc_pkg::ptc_state_t st_r;
  logic [7:0] pad_cnt_r;
  logic [7:0] col_r;
  logic [7:0] cur_r;
  logic       cur_is_echo_r;

  logic brk_disc;
  assign brk_disc = brk && online && brk_act_r[`PTC_BRK_DISC];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rc_sel_r   <= `PTC_RC_DEFAULT;
      brk_act_r  <= `PTC_BRK_DEFAULT;
      cr_pad_r   <= 8'h00;
      line_len_r <= 8'h00;
      flow_r     <= 1'b0;
      lf_ins_r   <= 3'h0;
      lf_pad_r   <= 8'h00;
      editing    <= 1'b0;
      term_type  <= `PTC_TTYPE_DISPLAY;
    end
    else if (set_we)
    begin
      case (set_num)
        5'h06: rc_sel_r <= set_val[2:0];
        5'h07: brk_act_r <= set_val[4:0];
        5'h09: cr_pad_r <= set_val;
        5'h0A: line_len_r <= set_val;
        5'h0C: flow_r <= set_val[0];
        5'h0D: lf_ins_r <= set_val[2:0];
        5'h0E: lf_pad_r <= set_val;
        5'h0F: editing <= set_val[0];
        5'h13: term_type <= set_val;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      discard_r <= 1'b0;
    else if (brk_disc)
      discard_r <= 1'b1;
    else if (set_we && set_remote && set_num == 5'h08)
      discard_r <= set_val[0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      set_refused <= 1'b0;
    else
      set_refused <= set_we && !set_remote && (set_num == 5'h08 ||
                     set_num == 5'h0B);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      speed_code <= 5'h00;
    else if (at_rate_we)
      speed_code <= at_rate_code;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rc_std_en    <= 1'b1;
      rc_prompt_en <= 1'b1;
    end
    else
    begin
      rc_std_en    <= (rc_sel_r == 3'h1) || (rc_sel_r == 3'h5);
      rc_prompt_en <= (rc_sel_r == 3'h4) || (rc_sel_r == 3'h5);
    end
  end

  // ------------------------------------------------------------
  // Break actions
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pkt_intr    <= 1'b0;
      pkt_reset   <= 1'b0;
      pkt_brk_ind <= 1'b0;
      to_command  <= 1'b0;
    end
    else
    begin
      pkt_intr    <= brk && online && brk_act_r[`PTC_BRK_INTR];
      pkt_reset   <= brk && online && brk_act_r[`PTC_BRK_RESET];
      pkt_brk_ind <= brk && online && brk_act_r[`PTC_BRK_IND];
      to_command  <= brk && online && brk_act_r[`PTC_BRK_ESC] &&
                     !modem_option_register[`PTC_OPT_NOBRKESC];
    end
  end

  // ------------------------------------------------------------
  // Flow control from terminal
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      xoff_r <= 1'b0;
    else if (!flow_r)
      xoff_r <= 1'b0;
    else if (term_vld && term_chr == `PTC_CH_XOFF)
      xoff_r <= 1'b1;
    else if (term_vld && term_chr == `PTC_CH_XON)
      xoff_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      net_vld     <= 1'b0;
      net_chr     <= `PTC_CH_NUL;
      net_lf_edit <= 1'b0;
    end
    else
    begin
      net_vld     <= 1'b0;
      net_lf_edit <= 1'b0;
      if (term_vld && !(flow_r && (term_chr == `PTC_CH_XON ||
          term_chr == `PTC_CH_XOFF)))
      begin
        net_vld <= 1'b1;
        net_chr <= term_chr;
      end
      else if (online && lf_ins_r[1] && net_vld &&
               net_chr == `PTC_CH_CR && !net_lf_edit)
      begin
        net_vld <= 1'b1;
        net_chr <= `PTC_CH_LF;
        net_lf_edit <= editing && lf_ins_r[2];
      end
    end
  end

  // ------------------------------------------------------------
  // Terminal output sequencer
  // ------------------------------------------------------------
  logic       out_ok;
  logic       accept;
  logic       is_graphic;
  logic [7:0] tab_col;
  assign out_ok  = !xoff_r && (!tx_vld || tx_rdy);
  // Echo wins over network data unless rx_rdy is already high with rx_vld; echo ignores discard
  assign accept  = (st_r == ptc_pkg::PTC_IDLE) && out_ok;
  assign is_graphic = cur_r >= 8'h20 && cur_r < 8'h7F;
  assign tab_col = {col_r[7:3] + 5'h01, 3'h0};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_rdy <= 1'b0;
    else
      rx_rdy <= accept && !echo_vld && !rx_rdy;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r          <= ptc_pkg::PTC_IDLE;
      cur_r         <= `PTC_CH_NUL;
      cur_is_echo_r <= 1'b0;
      pad_cnt_r     <= 8'h00;
      col_r         <= 8'h00;
      tx_vld        <= 1'b0;
      tx_chr        <= `PTC_CH_NUL;
    end
    else
    begin
      if (tx_vld && tx_rdy)
        tx_vld <= 1'b0;
      case (st_r)
        ptc_pkg::PTC_IDLE:
        begin
          // An offered network char must be consumed, or it is lost
          // drop while discarding
          if (rx_rdy && rx_vld && !discard_r)
          begin
            cur_r         <= rx_chr;
            cur_is_echo_r <= 1'b0;
            st_r          <= ptc_pkg::PTC_CHAR;
          end
          else if (accept && echo_vld)
          begin
            cur_r         <= echo_chr;
            cur_is_echo_r <= 1'b1;
            st_r          <= ptc_pkg::PTC_CHAR;
          end
        end
        ptc_pkg::PTC_CHAR:
        begin
          if (out_ok && line_len_r != 8'h00 && is_graphic &&
              col_r >= line_len_r)
          begin
            tx_vld <= 1'b1;
            tx_chr <= `PTC_CH_CR;
            col_r  <= 8'h00;
            st_r   <= ptc_pkg::PTC_FCR;
          end
          else if (out_ok)
          begin
            tx_vld <= 1'b1;
            tx_chr <= cur_r;
            pad_cnt_r <= cur_r == `PTC_CH_CR ? cr_pad_r : lf_pad_r;
            if (cur_r == `PTC_CH_BS)
              col_r <= col_r == 8'h00 ? 8'h00 : col_r - 8'h01;
            else if (cur_r == `PTC_CH_HT &&
                     term_type == `PTC_TTYPE_DISPLAY)
              col_r <= tab_col;
            else if (cur_r == `PTC_CH_CR)
              col_r <= 8'h00;
            else if (is_graphic)
              col_r <= col_r + 8'h01;
            if (cur_r == `PTC_CH_CR && cr_pad_r != 8'h00)
              st_r <= ptc_pkg::PTC_PCR;
            else if (cur_r == `PTC_CH_CR)
              st_r <= ptc_pkg::PTC_LF;
            else if (cur_r == `PTC_CH_LF && online &&
                     lf_pad_r != 8'h00)
              st_r <= ptc_pkg::PTC_PLF;
            else
              st_r <= ptc_pkg::PTC_IDLE;
          end
        end
        ptc_pkg::PTC_FCR:
          if (out_ok)
          begin
            tx_vld <= 1'b1;
            tx_chr <= `PTC_CH_LF;
            st_r   <= ptc_pkg::PTC_CHAR;
          end
        ptc_pkg::PTC_PCR, ptc_pkg::PTC_PLF:
          if (out_ok)
          begin
            tx_vld    <= 1'b1;
            tx_chr    <= `PTC_CH_NUL;
            pad_cnt_r <= pad_cnt_r - 8'h01;
            if (pad_cnt_r == 8'h01)
              st_r <= st_r == ptc_pkg::PTC_PCR ? ptc_pkg::PTC_LF
                                                 : ptc_pkg::PTC_IDLE;
          end
        ptc_pkg::PTC_LF:
          if (online && ((cur_is_echo_r && lf_ins_r[2]) ||
              (!cur_is_echo_r && lf_ins_r[0])))
          begin
            cur_r <= `PTC_CH_LF;
            st_r  <= ptc_pkg::PTC_CHAR;
          end
          else
            st_r <= ptc_pkg::PTC_IDLE;
        default:
          st_r <= ptc_pkg::PTC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_brk_intr;
    @(posedge clk) disable iff (rst)
    brk && online && brk_act_r[0] |=> pkt_intr;
  endproperty
  a_brk_intr: assert property (p_brk_intr)
    else $error("interrupt packet missing");

  property p_no_esc;
    @(posedge clk) disable iff (rst)
    modem_option_register[2] |=> !to_command;
  endproperty
  a_no_esc: assert property (p_no_esc)
    else $error("break escape despite option");

  property p_local_disc;
    @(posedge clk) disable iff (rst)
    set_we && !set_remote && set_num == 5'h08 && !brk
      |=> $stable(discard_r);
  endproperty
  a_local_disc: assert property (p_local_disc)
    else $error("local write changed discard");

  property p_brk_disc;
    @(posedge clk) disable iff (rst)
    brk && online && brk_act_r[4] |=> discard_r;
  endproperty
  a_brk_disc: assert property (p_brk_disc)
    else $error("break did not set discard");

  property p_xoff;
    @(posedge clk) disable iff (rst)
    xoff_r && !(tx_vld && !tx_rdy) |=> !$rose(tx_vld);
  endproperty
  a_xoff: assert property (p_xoff)
    else $error("output during xoff");

  property p_rc;
    @(posedge clk) disable iff (rst)
    rc_sel_r == 3'h0 |=> !rc_std_en && !rc_prompt_en;
  endproperty
  a_rc: assert property (p_rc)
    else $error("result codes with setting 0");

  property p_speed;
    @(posedge clk) disable iff (rst)
    at_rate_we |=> speed_code == $past(at_rate_code);
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed code not updated");

  property p_cr_pad;
    @(posedge clk) disable iff (rst)
    st_r == ptc_pkg::PTC_CHAR && out_ok && cur_r == 8'h0D &&
      cr_pad_r != 8'h00 && !(line_len_r != 8'h00 && is_graphic &&
      col_r >= line_len_r)
      |=> st_r == ptc_pkg::PTC_PCR;
  endproperty
  a_cr_pad: assert property (p_cr_pad)
    else $error("no CR padding");

  property p_lf_cmd;
    @(posedge clk) disable iff (rst)
    st_r == ptc_pkg::PTC_LF && !online |=> st_r == ptc_pkg::PTC_IDLE;
  endproperty
  a_lf_cmd: assert property (p_lf_cmd)
    else $error("LF inserted in command state");
endmodule : ptc_core

// [logic/ptc_defs.svh]
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH
// ------------------------------------------------------------
// Setting defaults and character codes
// ------------------------------------------------------------
`define PTC_RC_DEFAULT    3'h5
`define PTC_BRK_DEFAULT   5'h05
`define PTC_BRK_INTR      0
`define PTC_BRK_RESET     1
`define PTC_BRK_IND       2
`define PTC_BRK_ESC       3
`define PTC_BRK_DISC      4
`define PTC_OPT_NOBRKESC  2
`define PTC_CH_NUL        8'h00
`define PTC_CH_BS         8'h08
`define PTC_CH_HT         8'h09
`define PTC_CH_LF         8'h0A
`define PTC_CH_CR         8'h0D
`define PTC_CH_XON        8'h11
`define PTC_CH_XOFF       8'h13
`define PTC_TTYPE_DISPLAY 8'h02
`endif

// [logic/ptc_pkg.sv]
package ptc_pkg;
  typedef enum logic [2:0] {
    PTC_IDLE = 3'b000,
    PTC_CHAR = 3'b001,
    PTC_LF   = 3'b010,
    PTC_PCR  = 3'b011,
    PTC_PLF  = 3'b100,
    PTC_FCR  = 3'b101
  } ptc_state_t;
endpackage : ptc_pkg
